// file: logic/crs_register_set.sv
// programmer-visible register set: data registers, program counter, flags, return stack
`timescale 1ns/1ps

module crs_register_set
    import crs_pkg::*;
#(
    parameter int STACK_DEPTH = STACK_LEVELS
) (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              clkEn,
    // data-space port
    input  wire logic [7:0]        dataAddr,
    input  wire logic              dataWrEn,
    input  wire logic [DATA_W-1:0] dataWrData,
    input  wire logic              dataRdEn,
    output logic      [DATA_W-1:0] dataRdData,
    output logic                   dataHit,
    // accumulator port from the alu
    input  wire logic              accWrEn,
    input  wire logic [DATA_W-1:0] accWrData,
    // program counter control from the sequencer
    input  crs_pcop_e              pcOp,
    input  wire logic [PC_W-1:0]   pcTarget,
    input  wire logic [DATA_W-1:0] relOffset,
    // flag updates from the alu
    input  wire logic              carryWrEn,
    input  wire logic              carryIn,
    input  wire logic              zeroWrEn,
    input  wire logic              zeroIn,
    // register contents
    output logic      [DATA_W-1:0] accumulator,
    output logic      [DATA_W-1:0] pointerFirst,
    output logic      [DATA_W-1:0] pointerSecond,
    output logic      [DATA_W-1:0] shortDirectFirst,
    output logic      [DATA_W-1:0] shortDirectSecond,
    output logic      [PC_W-1:0]   progCounter,
    output logic                   activeCarry,
    output logic                   activeZero,
    output crs_ctx_e               activeCtx,
    output logic                   stackEmpty,
    output logic                   stackFull
);

    localparam int DEPTH_W = $clog2(STACK_DEPTH + 1);
    localparam logic [DEPTH_W-1:0] DEPTH_MAX  = DEPTH_W'(STACK_DEPTH);
    localparam logic [DEPTH_W-1:0] DEPTH_ZERO = '0;
    localparam logic [DEPTH_W-1:0] DEPTH_ONE  = DEPTH_W'(1);

    if (STACK_DEPTH < 2) begin : gBadDepth
        $error("crs_register_set: STACK_DEPTH must be at least 2");
    end

    // ----------------------------------------------------------------
    // data-space decode
    // ----------------------------------------------------------------
    function automatic logic isReg(input logic [7:0] addr, input logic [7:0] regAddr);
        return addr == regAddr;
    endfunction

    logic wrAcc, wrPtr1, wrPtr2, wrSd1, wrSd2;
    logic hitAcc, hitPtr1, hitPtr2, hitSd1, hitSd2;
    logic [DATA_W-1:0] rdMux;

    assign hitAcc  = isReg(dataAddr, ADDR_ACCUMULATOR);
    assign hitPtr1 = isReg(dataAddr, ADDR_POINTER_FIRST);
    assign hitPtr2 = isReg(dataAddr, ADDR_POINTER_SECOND);
    assign hitSd1  = isReg(dataAddr, ADDR_SHORT_DIRECT_FIRST);
    assign hitSd2  = isReg(dataAddr, ADDR_SHORT_DIRECT_SECOND);
    assign dataHit = hitAcc | hitPtr1 | hitPtr2 | hitSd1 | hitSd2;

    assign wrAcc  = dataWrEn & hitAcc;
    assign wrPtr1 = dataWrEn & hitPtr1;
    assign wrPtr2 = dataWrEn & hitPtr2;
    assign wrSd1  = dataWrEn & hitSd1;
    assign wrSd2  = dataWrEn & hitSd2;

    assign rdMux = hitAcc  ? accumulator       :
                   hitPtr1 ? pointerFirst      :
                   hitPtr2 ? pointerSecond     :
                   hitSd1  ? shortDirectFirst  :
                   hitSd2  ? shortDirectSecond : DATA_RESET;

    // ----------------------------------------------------------------
    // data registers
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] acc_q, acc_d;
    logic [DATA_W-1:0] ptr1_q, ptr2_q, sd1_q, sd2_q, rd_q;

    // alu write wins over a data-space write in the same cycle
    assign acc_d = accWrEn ? accWrData : dataWrData;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            acc_q  <= DATA_RESET;
            ptr1_q <= DATA_RESET;
            ptr2_q <= DATA_RESET;
            sd1_q  <= DATA_RESET;
            sd2_q  <= DATA_RESET;
            rd_q   <= DATA_RESET;
        end else if (clkEn) begin
            if (accWrEn || wrAcc) acc_q <= acc_d;
            if (wrPtr1) ptr1_q <= dataWrData;
            if (wrPtr2) ptr2_q <= dataWrData;
            if (wrSd1)  sd1_q  <= dataWrData;
            if (wrSd2)  sd2_q  <= dataWrData;
            if (dataRdEn) rd_q <= rdMux;
        end
    end

    assign accumulator       = acc_q;
    assign pointerFirst      = ptr1_q;
    assign pointerSecond     = ptr2_q;
    assign shortDirectFirst  = sd1_q;
    assign shortDirectSecond = sd2_q;
    assign dataRdData        = rd_q;

    // ----------------------------------------------------------------
    // operation decode
    // ----------------------------------------------------------------
    logic isPush, isRet, isReti, popOk;
    logic [DEPTH_W-1:0] depth_q, depth_d;

    assign isPush = (pcOp == PC_CALL) | (pcOp == PC_IRQ_ENTRY) | (pcOp == PC_NMI_ENTRY);
    assign isReti = (pcOp == PC_INTERRUPT_RETURN);
    assign isRet  = (pcOp == PC_SUBROUTINE_RETURN) | isReti;
    assign popOk  = isRet & (depth_q != DEPTH_ZERO);

    // ----------------------------------------------------------------
    // program counter
    // ----------------------------------------------------------------
    logic [PC_W-1:0] pc_q, pc_d, pcPlusOne, pcRel;
    logic [PC_W-1:0] stack_q [STACK_DEPTH];
    logic [PC_W-1:0] stack_d [STACK_DEPTH];

    // 12 bits only; wider program space is banked outside this block
    assign pcPlusOne = pc_q + PC_ONE;
    assign pcRel     = pc_q + {{(PC_W-DATA_W){relOffset[DATA_W-1]}}, relOffset};

    always_comb begin
        case (pcOp)
            PC_HOLD:              pc_d = pc_q;
            PC_INC:               pc_d = pcPlusOne;
            PC_REL:               pc_d = pcRel;
            PC_JUMP_INSTR,
            PC_CALL,
            PC_IRQ_ENTRY,
            PC_NMI_ENTRY:         pc_d = pcTarget;
            PC_SUBROUTINE_RETURN,
            PC_INTERRUPT_RETURN:  pc_d = popOk ? stack_q[0] : pcPlusOne;
            default:              pc_d = pc_q;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pc_q <= RESET_VECTOR;
        end else if (clkEn) begin
            pc_q <= pc_d;
        end
    end

    assign progCounter = pc_q;

    // ----------------------------------------------------------------
    // return stack: shift register of program counter values only
    // ----------------------------------------------------------------
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : gStack
        logic [PC_W-1:0] deeper, shallower;
        if (i == 0) begin : gTop
            assign deeper = pc_q;
        end else begin : gMid
            assign deeper = stack_q[i-1];
        end
        if (i == STACK_DEPTH - 1) begin : gBottom
            assign shallower = '0;
        end else begin : gUpper
            assign shallower = stack_q[i+1];
        end
        // the oldest level simply falls off the end on a push
        assign stack_d[i] = isPush ? deeper : (popOk ? shallower : stack_q[i]);
    end

    assign depth_d = isPush ? ((depth_q == DEPTH_MAX) ? DEPTH_MAX : depth_q + DEPTH_ONE) :
                     popOk  ? depth_q - DEPTH_ONE : depth_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            depth_q <= DEPTH_ZERO;
            for (int k = 0; k < STACK_DEPTH; k++) begin
                stack_q[k] <= '0;
            end
        end else if (clkEn) begin
            depth_q <= depth_d;
            stack_q <= stack_d;
        end
    end

    assign stackEmpty = (depth_q == DEPTH_ZERO);
    assign stackFull  = (depth_q == DEPTH_MAX);

    // ----------------------------------------------------------------
    // flag context
    // ----------------------------------------------------------------
    crs_ctx_e ctx_q, ctx_d, irqPrev_q, nmiPrev_q, retCtx;

    assign retCtx = (ctx_q == CTX_NMI) ? nmiPrev_q :
                    (ctx_q == CTX_IRQ) ? irqPrev_q : CTX_MAIN;

    assign ctx_d = (pcOp == PC_NMI_ENTRY) ? CTX_NMI :
                   (pcOp == PC_IRQ_ENTRY) ? CTX_IRQ :
                   isReti                 ? retCtx  : ctx_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctx_q     <= CTX_NMI;
            nmiPrev_q <= CTX_MAIN;
            irqPrev_q <= CTX_MAIN;
        end else if (clkEn) begin
            ctx_q <= ctx_d;
            if (pcOp == PC_NMI_ENTRY) nmiPrev_q <= ctx_q;
            if (pcOp == PC_IRQ_ENTRY) irqPrev_q <= ctx_q;
        end
    end

    assign activeCtx = ctx_q;

    // ----------------------------------------------------------------
    // flag pairs: only the active pair is written or seen
    // ----------------------------------------------------------------
    logic [2:0] ctxSel;
    logic [2:0] carry_q, zero_q;

    assign ctxSel = {ctx_q == CTX_NMI, ctx_q == CTX_IRQ, ctx_q == CTX_MAIN};

    for (genvar c = 0; c < 3; c++) begin : gFlags
        always_ff @(posedge core_clk) begin
            if (reset) begin
                carry_q[c] <= FLAG_RESET;
                zero_q[c]  <= FLAG_RESET;
            end else if (clkEn && ctxSel[c]) begin
                if (carryWrEn) carry_q[c] <= carryIn;
                if (zeroWrEn)  zero_q[c]  <= zeroIn;
            end
        end
    end

    // active carry feeds the rotate-left path of the alu
    assign activeCarry = |(carry_q & ctxSel);
    assign activeZero  = |(zero_q & ctxSel);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    acc_write_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && wrAcc && !accWrEn |=> accumulator == $past(dataWrData))
        else $error("accumulator missed a data-space write");

    ptr_read_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && dataRdEn && hitPtr2 && !dataWrEn |=> dataRdData == pointerSecond)
        else $error("second pointer read returned wrong data");

    sd_write_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && wrSd1 |=> shortDirectFirst == $past(dataWrData))
        else $error("short direct register missed a write");

    pc_inc_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && pcOp == PC_INC |=> progCounter == $past(progCounter) + PC_ONE)
        else $error("program counter did not increment");

    pc_rel_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && pcOp == PC_REL ##1 clkEn && pcOp == PC_INC
        |=> progCounter == $past(pcRel, 2) + PC_ONE)
        else $error("relative branch produced wrong target");

    pc_load_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && (pcOp == PC_JUMP_INSTR || pcOp == PC_IRQ_ENTRY) |=> progCounter == $past(pcTarget))
        else $error("program counter did not take the target");

    reset_ctx_a: assert property (@(posedge core_clk) disable iff (reset)
        $fell(reset) |-> activeCtx == CTX_NMI && progCounter == RESET_VECTOR && stackEmpty)
        else $error("reset did not select the non-maskable context");

    irq_ctx_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && pcOp == PC_IRQ_ENTRY ##1 clkEn && pcOp == PC_INTERRUPT_RETURN
        |=> activeCtx == $past(activeCtx, 2))
        else $error("interrupt return did not restore the previous context");

    flag_keep_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && ctx_q != CTX_MAIN |=> carry_q[0] == $past(carry_q[0]) && zero_q[0] == $past(zero_q[0]))
        else $error("an inactive flag pair changed");

    carry_set_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && carryWrEn && pcOp == PC_HOLD |=> activeCarry == $past(carryIn))
        else $error("active carry did not follow the alu");

    zero_set_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && zeroWrEn && pcOp == PC_HOLD |=> activeZero == $past(zeroIn))
        else $error("active zero did not follow the alu");

    stack_push_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && isPush |=> stack_q[0] == $past(pc_q) && stack_q[1] == $past(stack_q[0]))
        else $error("push did not shift the stack");

    stack_pop_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && popOk |=> progCounter == $past(stack_q[0]) && stack_q[0] == $past(stack_q[1]))
        else $error("return did not pop the stack");

    depth_sat_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && isPush && stackFull |=> stackFull)
        else $error("stack left its deepest position on overflow");

    empty_ret_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && isRet && stackEmpty |=> stackEmpty && progCounter == $past(pcPlusOne))
        else $error("return on empty stack misbehaved");

    push_acc_a: assert property (@(posedge core_clk) disable iff (reset)
        clkEn && isPush && !accWrEn && !wrAcc |=> accumulator == $past(accumulator))
        else $error("a push disturbed the accumulator");

endmodule // crs_register_set

// file: logic/crs_pkg.sv
// constants and types shared by the core register set
package crs_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int DATA_W       = 8;
    localparam int PC_W         = 12;
    localparam int STACK_LEVELS = 6;

    // ----------------------------------------------------------------
    // data-space byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_POINTER_FIRST       = 8'h80;
    localparam logic [7:0] ADDR_POINTER_SECOND      = 8'h81;
    localparam logic [7:0] ADDR_SHORT_DIRECT_FIRST  = 8'h82;
    localparam logic [7:0] ADDR_SHORT_DIRECT_SECOND = 8'h83;
    localparam logic [7:0] ADDR_ACCUMULATOR         = 8'hFF;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] DATA_RESET   = 8'h00;
    localparam logic [PC_W-1:0]   RESET_VECTOR = 12'h000;
    localparam logic [PC_W-1:0]   PC_ONE       = 12'h001;
    localparam logic              FLAG_RESET   = 1'b0;

    // ----------------------------------------------------------------
    // flag contexts and program counter operations
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CTX_MAIN,
        CTX_IRQ,
        CTX_NMI
    } crs_ctx_e;

    typedef enum logic [3:0] {
        PC_HOLD,
        PC_INC,
        PC_REL,
        PC_JUMP_INSTR,
        PC_CALL,
        PC_IRQ_ENTRY,
        PC_NMI_ENTRY,
        PC_SUBROUTINE_RETURN,
        PC_INTERRUPT_RETURN
    } crs_pcop_e;

endpackage

// file: dv/crs_seq_model.sv
// sequencer, alu and data-bus model that drives the register set
`timescale 1ns/1ps

module crs_seq_model
    import crs_pkg::*;
(
    input  wire logic        core_clk,
    output logic             clkEn,
    output logic [7:0]       dataAddr,
    output logic             dataWrEn,
    output logic [7:0]       dataWrData,
    output logic             dataRdEn,
    output logic             accWrEn,
    output logic [7:0]       accWrData,
    output crs_pcop_e        pcOp,
    output logic [PC_W-1:0]  pcTarget,
    output logic [7:0]       relOffset,
    output logic             carryWrEn,
    output logic             carryIn,
    output logic             zeroWrEn,
    output logic             zeroIn
);
    // ----------------------------------------------------------------
    // staged request: setters fill it, step drives it for one edge
    // ----------------------------------------------------------------
    logic             sEn      = 1'b1;
    logic [7:0]       sAddr    = 8'h00;
    logic             sWr      = 1'b0;
    logic [7:0]       sWrData  = 8'h00;
    logic             sRd      = 1'b0;
    logic             sAccWr   = 1'b0;
    logic [7:0]       sAccData = 8'h00;
    crs_pcop_e        sOp      = PC_HOLD;
    logic [PC_W-1:0]  sTarget  = 12'h000;
    logic [7:0]       sOffset  = 8'h00;
    logic             sFlagWr  = 1'b0;
    logic             sCarry   = 1'b0;
    logic             sZero    = 1'b0;

    task automatic setEn(input logic e);
        sEn = e;
    endtask

    task automatic setPc(input crs_pcop_e op, input logic [PC_W-1:0] t, input logic [7:0] o);
        sOp     = op;
        sTarget = t;
        sOffset = o;
    endtask

    task automatic setData(input logic w, input logic r, input logic [7:0] a,
                           input logic [7:0] d);
        sWr     = w;
        sRd     = r;
        sAddr   = a;
        sWrData = d;
    endtask

    task automatic setAlu(input logic aw, input logic [7:0] ad, input logic fw,
                          input logic c, input logic z);
        sAccWr   = aw;
        sAccData = ad;
        sFlagWr  = fw;
        sCarry   = c;
        sZero    = z;
    endtask

    // ----------------------------------------------------------------
    // step: every pin written once per falling edge, stage back to idle
    // ----------------------------------------------------------------
    task automatic step();
        clkEn      = sEn;
        dataAddr   = sAddr;
        dataWrEn   = sWr;
        dataWrData = sWrData;
        dataRdEn   = sRd;
        accWrEn    = sAccWr;
        accWrData  = sAccData;
        pcOp       = sOp;
        pcTarget   = sTarget;
        relOffset  = sOffset;
        carryWrEn  = sFlagWr;
        carryIn    = sCarry;
        zeroWrEn   = sFlagWr;
        zeroIn     = sZero;
        // idle strobes, data and target buses scrambled
        sWr        = 1'b0;
        sRd        = 1'b0;
        sAccWr     = 1'b0;
        sFlagWr    = 1'b0;
        sOp        = PC_HOLD;
        sWrData    = ~sWrData;
        sAccData   = ~sAccData;
        sTarget    = ~sTarget;
        @(negedge core_clk);
    endtask
endmodule // crs_seq_model

// file: dv/crs_register_set_tb.sv
// self-checking bench for the core register set
`timescale 1ns/1ps

module crs_register_set_tb
    import crs_pkg::*;
;
    logic             core_clk, reset, clkEn, dataWrEn, dataRdEn, dataHit, accWrEn;
    logic             carryWrEn, carryIn, zeroWrEn, zeroIn, activeCarry, activeZero;
    logic             stackEmpty, stackFull;
    logic [7:0]       dataAddr, dataWrData, dataRdData, accWrData, relOffset, accumulator;
    logic [7:0]       pointerFirst, pointerSecond, shortDirectFirst, shortDirectSecond;
    logic [PC_W-1:0]  pcTarget, progCounter, expPc;
    logic [PC_W-1:0]  expStk[$];
    crs_pcop_e        pcOp;
    crs_ctx_e         activeCtx, expCtx, savedIrq, savedNmi;
    logic [2:0]       expC, expZ;
    logic [7:0]       vals[5];
    logic [7:0]       addrs[5] = '{ADDR_POINTER_FIRST, ADDR_POINTER_SECOND,
                                   ADDR_SHORT_DIRECT_FIRST, ADDR_SHORT_DIRECT_SECOND,
                                   ADDR_ACCUMULATOR};
    int               errorCnt = 0;
    int               comparisons = 0;

    crs_register_set i_crs_register_set (
        .core_clk(core_clk), .reset(reset), .clkEn(clkEn), .dataAddr(dataAddr),
        .dataWrEn(dataWrEn), .dataWrData(dataWrData), .dataRdEn(dataRdEn),
        .dataRdData(dataRdData), .dataHit(dataHit), .accWrEn(accWrEn), .accWrData(accWrData),
        .pcOp(pcOp), .pcTarget(pcTarget), .relOffset(relOffset), .carryWrEn(carryWrEn),
        .carryIn(carryIn), .zeroWrEn(zeroWrEn), .zeroIn(zeroIn), .accumulator(accumulator),
        .pointerFirst(pointerFirst), .pointerSecond(pointerSecond),
        .shortDirectFirst(shortDirectFirst), .shortDirectSecond(shortDirectSecond),
        .progCounter(progCounter), .activeCarry(activeCarry), .activeZero(activeZero),
        .activeCtx(activeCtx), .stackEmpty(stackEmpty), .stackFull(stackFull));

    crs_seq_model i_crs_seq_model (
        .core_clk(core_clk), .clkEn(clkEn), .dataAddr(dataAddr), .dataWrEn(dataWrEn),
        .dataWrData(dataWrData), .dataRdEn(dataRdEn), .accWrEn(accWrEn),
        .accWrData(accWrData), .pcOp(pcOp), .pcTarget(pcTarget), .relOffset(relOffset),
        .carryWrEn(carryWrEn), .carryIn(carryIn), .zeroWrEn(zeroWrEn), .zeroIn(zeroIn));

    // ----------------------------------------------------------------
    // clock, watchdog, report
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge core_clk);
        errorCnt++;
        $display("ERROR watchdog expected end of run seen none");
        summarize();
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errorCnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // ----------------------------------------------------------------
    // access tasks with the expected-state model
    // ----------------------------------------------------------------
    task automatic resetDut();
        reset = 1'b1;
        repeat (12) i_crs_seq_model.step();
        reset = 1'b0;
        expPc = RESET_VECTOR;
        expStk.delete();
        expCtx = CTX_NMI;
        savedIrq = CTX_MAIN;
        savedNmi = CTX_MAIN;
        expC = 3'b000;
        expZ = 3'b000;
        vals = '{default: 8'h00};
    endtask

    task automatic checkRegs();
        check("pointerFirst", 16'(pointerFirst), 16'(vals[0]));
        check("pointerSecond", 16'(pointerSecond), 16'(vals[1]));
        check("shortDirectFirst", 16'(shortDirectFirst), 16'(vals[2]));
        check("shortDirectSecond", 16'(shortDirectSecond), 16'(vals[3]));
        check("accumulator", 16'(accumulator), 16'(vals[4]));
    endtask

    task automatic regAccess(input logic [7:0] a, input logic [7:0] d, input logic hit);
        i_crs_seq_model.setData(1'b1, 1'b0, a, d);
        i_crs_seq_model.step();
        check("dataHit", 16'(dataHit), 16'(hit));
        i_crs_seq_model.setData(1'b0, 1'b1, a, 8'h00);
        i_crs_seq_model.step();
        check("dataRdData", 16'(dataRdData), hit ? 16'(d) : 16'h0000);
    endtask

    task automatic exec(input crs_pcop_e op, input logic [PC_W-1:0] tgt = 12'h000,
                        input logic [7:0] off = 8'h00, input logic fw = 1'b0,
                        input logic c = 1'b0, input logic z = 1'b0);
        i_crs_seq_model.setPc(op, tgt, off);
        i_crs_seq_model.setAlu(1'b0, 8'h00, fw, c, z);
        i_crs_seq_model.step();
        if (fw) begin
            expC[expCtx] = c;
            expZ[expCtx] = z;
        end
        case (op)
            PC_INC: expPc = expPc + PC_ONE;
            PC_REL: expPc = expPc + {{4{off[7]}}, off};
            PC_JUMP_INSTR: expPc = tgt;
            PC_CALL, PC_IRQ_ENTRY, PC_NMI_ENTRY: begin
                expStk.push_front(expPc);
                if (expStk.size() > STACK_LEVELS) begin
                    void'(expStk.pop_back());
                end
                expPc = tgt;
            end
            PC_SUBROUTINE_RETURN, PC_INTERRUPT_RETURN: begin
                if (expStk.size() == 0) begin
                    expPc = expPc + PC_ONE;
                end else begin
                    expPc = expStk.pop_front();
                end
            end
            default: ;
        endcase
        if (op == PC_INTERRUPT_RETURN) begin
            expCtx = (expCtx == CTX_NMI) ? savedNmi : savedIrq;
        end
        if (op == PC_IRQ_ENTRY) begin
            savedIrq = expCtx;
            expCtx = CTX_IRQ;
        end
        if (op == PC_NMI_ENTRY) begin
            savedNmi = expCtx;
            expCtx = CTX_NMI;
        end
        check("progCounter", 16'(progCounter), 16'(expPc));
        check("activeCtx", 16'(activeCtx), 16'(expCtx));
        check("activeCarry", 16'(activeCarry), 16'(expC[expCtx]));
        check("activeZero", 16'(activeZero), 16'(expZ[expCtx]));
        check("stackEmpty", 16'(stackEmpty), 16'(expStk.size() == 0));
        check("stackFull", 16'(stackFull), 16'(expStk.size() == STACK_LEVELS));
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        resetDut();
        exec(PC_HOLD);
        checkRegs();
        for (int i = 0; i < 5; i++) begin
            vals[i] = 8'(8'h5A + 37 * i);
            regAccess(addrs[i], vals[i], 1'b1);
        end
        regAccess(8'h84, 8'h77, 1'b0);
        regAccess(8'h7F, 8'h66, 1'b0);
        checkRegs();
        // data write to the accumulator loses to the alu in the same cycle
        i_crs_seq_model.setData(1'b1, 1'b0, ADDR_ACCUMULATOR, 8'hAA);
        i_crs_seq_model.setAlu(1'b1, 8'h33, 1'b0, 1'b0, 1'b0);
        i_crs_seq_model.step();
        vals[4] = 8'h33;
        checkRegs();
        repeat (3) exec(PC_INC);
        exec(PC_REL, , 8'h05);
        exec(PC_REL, , 8'hFD);
        exec(PC_REL, , 8'h80);
        exec(PC_INC);
        exec(PC_JUMP_INSTR, 12'hFFF);
        exec(PC_INC);
        exec(PC_HOLD, , , 1'b1, 1'b1, 1'b1);
        exec(PC_INTERRUPT_RETURN);
        exec(PC_HOLD, , , 1'b1, 1'b0, 1'b1);
        exec(PC_IRQ_ENTRY, 12'h040, , 1'b1, 1'b1, 1'b0);
        exec(PC_HOLD, , , 1'b1, 1'b0, 1'b1);
        exec(PC_NMI_ENTRY, 12'h0C0);
        exec(PC_INTERRUPT_RETURN);
        exec(PC_INTERRUPT_RETURN);
        exec(PC_IRQ_ENTRY, 12'h080);
        exec(PC_INTERRUPT_RETURN);
        exec(PC_JUMP_INSTR, 12'h010);
        for (int i = 0; i < 7; i++) begin
            exec(PC_CALL, 12'(12'h100 + 16 * i));
        end
        repeat (7) exec(PC_SUBROUTINE_RETURN);
        checkRegs();
        // with the clock enable low nothing may move
        i_crs_seq_model.setEn(1'b0);
        i_crs_seq_model.setPc(PC_INC, 12'h000, 8'h00);
        i_crs_seq_model.setData(1'b1, 1'b0, ADDR_POINTER_FIRST, 8'h00);
        i_crs_seq_model.step();
        check("progCounter", 16'(progCounter), 16'(expPc));
        checkRegs();
        i_crs_seq_model.setEn(1'b1);
        resetDut();
        exec(PC_HOLD);
        checkRegs();
        summarize();
    end
endmodule // crs_register_set_tb
